// ### hw/gma_pkg.sv
// package for the graphics memory allocator: buffer limits, defaults, vector byte costs
// assumes a 10 MHz core clock and 14-bit byte counts
package gma_pkg;
  localparam int GMA_SW = 14;
  localparam logic [13:0] GMA_TOTAL = 14'h3200;
  localparam logic [13:0] GMA_IO_MIN = 14'h0002;
  localparam logic [13:0] GMA_IO_MAX = 14'h31D0;
  localparam logic [13:0] GMA_IO_DEF = 14'h0400;
  localparam logic [13:0] GMA_PG_MIN = 14'h0004;
  localparam logic [13:0] GMA_PG_MAX = 14'h31D2;
  localparam logic [13:0] GMA_PG_DEF = 14'h06F2;
  localparam logic [13:0] GMA_CH_MIN_DEF = 14'h01C4;
  localparam logic [13:0] GMA_CH_MAX = 14'h31CE;
  localparam logic [13:0] GMA_CH_DEF = 14'h0000;
  localparam logic [13:0] GMA_RP_MAX = 14'h31CE;
  localparam logic [13:0] GMA_RP_DEF = 14'h26E2;
  localparam logic [13:0] GMA_VC_MIN = 14'h002C;
  localparam logic [13:0] GMA_VC_MAX = 14'h31FA;
  localparam logic [13:0] GMA_VC_DEF = 14'h002C;
  localparam logic [13:0] GMA_VEC_BYTES_OFF = 14'h0016;
  localparam logic [13:0] GMA_VEC_BYTES_ON = 14'h000A;
  localparam logic [7:0] GMA_CH_ESC = 8'h1B;
  localparam logic [7:0] GMA_CH_DOT = 8'h2E;
  localparam logic [7:0] GMA_CH_ALLOC = 8'h54;
  localparam logic [7:0] GMA_CH_SEMI = 8'h3B;
  localparam logic [7:0] GMA_CH_COLON = 8'h3A;
  localparam int GMA_NBUF = 5;
  localparam logic [2:0] GMA_IDX_IO = 3'h0;
  localparam logic [2:0] GMA_IDX_PG = 3'h1;
  localparam logic [2:0] GMA_IDX_CH = 3'h2;
  localparam logic [2:0] GMA_IDX_RP = 3'h3;
  localparam logic [2:0] GMA_IDX_VC = 3'h4;
  typedef enum logic [2:0] {
    GMA_IDLE = 3'b000,
    GMA_DOT = 3'b001,
    GMA_FUNC = 3'b010,
    GMA_PARAM = 3'b011,
    GMA_FLUSH = 3'b100,
    GMA_DRAIN = 3'b101,
    GMA_REDUCE = 3'b110,
    GMA_COMMIT = 3'b111
  } gma_state_t;
endpackage

// ### hw/gma_clamp.sv
// per-buffer size conditioning: default, even rounding, ceiling, floor
// assumes the caller supplies parsed value and a present flag
`timescale 1ns/1ns
`default_nettype none
module gma_clamp #(
  parameter int W = 14
) (
  input wire logic [W-1:0] req_in, // parsed decimal value
  input wire logic present_in, // parameter was given
  input wire logic [W-1:0] def_in, // default size
  input wire logic [W-1:0] min_in, // minimum size
  input wire logic [W-1:0] max_in, // maximum size
  output logic [W-1:0] size_out // conditioned size
);
  logic [W-1:0] v;
  always_comb begin
    v = present_in ? req_in : def_in;
    v = {v[W-1:1], 1'b0};
    if (v > max_in) begin
      v = max_in;
    end
    if (v < min_in) begin
      v = min_in;
    end
    size_out = v;
  end
endmodule
`default_nettype wire

// ### hw/gma_allocator.sv
// graphics memory allocator: parses the allocate memory command and partitions 12800 bytes
// assumes command bytes arrive synchronous to clk_in with a one-cycle valid strobe
// assumes the drain, glyph and curve flags are steady levels from the buffer manager
// the sizes and pulses it produces are meant for that buffer manager around it
`timescale 1ns/1ns
`default_nettype none
module gma_allocator
  import gma_pkg::*;
#(
  parameter int W = gma_pkg::GMA_SW
) (
  input wire logic clk_in, // 10 MHz clock
  input wire logic reset_n_in, // async reset, active low
  input wire logic [7:0] cmd_byte_in, // host byte
  input wire logic cmd_valid_in, // byte strobe
  input wire logic glyphs_defined_in, // downloaded glyphs exist
  input wire logic curve_on_in, // curve generator enabled
  input wire logic vector_empty_in, // vector buffer drained
  input wire logic config_grow_in, // set configuration pulse
  input wire logic [W-1:0] config_logical_in, // requested logical io size
  input wire logic [W-1:0] io_queued_in, // bytes waiting for parsing
  input wire logic [W-1:0] vector_count_in, // vectors held
  input wire logic [W-1:0] panel_pending_in, // panel actions queued
  output logic io_clear_out, // clear io buffer pulse
  output logic buffers_clear_out, // clear all buffers pulse
  output logic parser_reset_out, // parser reset pulse
  output logic busy_out, // allocation in progress
  output logic [W-1:0] io_size_out, // physical io size
  output logic [W-1:0] poly_size_out, // polygon size, used by polygon commands
  output logic [W-1:0] glyph_size_out, // glyph size
  output logic [W-1:0] replot_size_out, // replot size
  output logic [W-1:0] vector_size_out, // vector size
  output logic [W-1:0] logical_size_out, // logical io size
  output logic io_full_out, // queued io reached logical size
  output logic [W-1:0] vector_capacity_out, // vectors that fit
  output logic vector_full_out, // vector buffer full
  output logic group_release_out, // release vectors as one group
  output logic pen_stop_out, // stop at every endpoint
  output logic panel_hold_out // panel actions held
);
  typedef struct packed {
    gma_state_t st;
    logic [2:0] idx;
    logic [W-1:0] acc;
    logic [GMA_NBUF-1:0] pres;
    logic [GMA_NBUF-1:0][W-1:0] req;
    logic [GMA_NBUF-1:0][W-1:0] sz;
    logic [GMA_NBUF-1:0] done;
    logic [W-1:0] logical;
    logic [W-1:0] cap_on;
    logic [W-1:0] cap_off;
    logic io_clr;
    logic buf_clr;
    logic prs_rst;
  } gma_regs_t;

  gma_regs_t q_r, q_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // per-buffer conditioning
  // each slot: default when omitted, then even, ceiling, floor
  logic [GMA_NBUF-1:0][W-1:0] cond;
  logic [GMA_NBUF-1:0][W-1:0] mins;

  // the glyph floor follows the live definitions flag, the only floor not fixed
  always_comb begin
    mins = {W'(GMA_VC_MIN), {W{1'b0}}, (glyphs_defined_in ? W'(GMA_CH_MIN_DEF) : {W{1'b0}}),
      W'(GMA_PG_MIN), W'(GMA_IO_MIN)};
  end

  genvar gi;
  generate
    for (gi = 0; gi < GMA_NBUF; gi++) begin : g_clamp
      logic [W-1:0] def_v;
      logic [W-1:0] max_v;

      // default and ceiling of this slot, fixed at elaboration
      if (gi == GMA_IDX_IO) begin : g_io
        assign def_v = W'(GMA_IO_DEF);
        assign max_v = W'(GMA_IO_MAX);
      end else if (gi == GMA_IDX_PG) begin : g_pg
        assign def_v = W'(GMA_PG_DEF);
        assign max_v = W'(GMA_PG_MAX);
      end else if (gi == GMA_IDX_CH) begin : g_ch
        assign def_v = W'(GMA_CH_DEF);
        assign max_v = W'(GMA_CH_MAX);
      end else if (gi == GMA_IDX_RP) begin : g_rp
        assign def_v = W'(GMA_RP_DEF);
        assign max_v = W'(GMA_RP_MAX);
      end else begin : g_vc
        assign def_v = W'(GMA_VC_DEF);
        assign max_v = W'(GMA_VC_MAX);
      end

      gma_clamp #(.W(W)) u_clamp (
        .req_in(q_r.req[gi]),
        .present_in(q_r.pres[gi]),
        .def_in(def_v),
        .min_in(mins[gi]),
        .max_in(max_v),
        .size_out(cond[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // largest not yet reduced buffer and running total
  logic [W+2:0] total;
  logic [2:0] big;
  logic [W-1:0] big_sz, excess, cut, slack;
  logic big_ok;
  always_comb begin
    total = '0;
    big = 3'h0;
    big_sz = '0;
    big_ok = 1'b0;

    for (int i = 0; i < GMA_NBUF; i++) begin
      total = total + {3'h0, q_r.sz[i]};
      // ties pick the earlier parameter
      if (!q_r.done[i] && (!big_ok || q_r.sz[i] > big_sz)) begin
        big = 3'(i);
        big_sz = q_r.sz[i];
        big_ok = 1'b1;
      end
    end

    excess = (total > {3'h0, GMA_TOTAL}) ? W'(total - {3'h0, GMA_TOTAL}) : '0;
    // slack is clipped at zero so replot cannot wrap when floors leave an excess behind
    slack = (total < {3'h0, GMA_TOTAL}) ? W'({3'h0, GMA_TOTAL} - total) : '0;
    // reduction never goes below that buffer's minimum, keeping it even
    cut = (big_sz - excess < mins[big] || excess > big_sz) ? mins[big] : big_sz - excess;
    cut = {cut[W-1:1], 1'b0};
  end

  ////////////////////////////////////////////////////////////////////////////
  // decimal digit accumulation, saturating well above every maximum
  logic [W+4:0] acc_x10;
  logic [W-1:0] acc_sat;
  logic is_digit;
  logic is_delim;
  logic slot_ok;

  always_comb begin
    is_digit = (cmd_byte_in >= 8'h30) && (cmd_byte_in <= 8'h39);
    is_delim = (cmd_byte_in == GMA_CH_SEMI) || (cmd_byte_in == GMA_CH_COLON);
    // parameters past the fifth are parsed but have no slot to land in
    slot_ok = q_r.idx < 3'(GMA_NBUF);
    acc_x10 = {5'h00, q_r.acc} * 19'h0000A + {15'h0000, cmd_byte_in[3:0]};
    // saturation keeps a long digit string from wrapping into a small, legal size
    acc_sat = (acc_x10 > {5'h00, {W{1'b1}}}) ? {W{1'b1}} : W'(acc_x10);
  end

  ////////////////////////////////////////////////////////////////////////////
  // logical io size requested by a set configuration pulse
  logic [W-1:0] grow_val;
  always_comb begin
    grow_val = config_logical_in;
    if (grow_val > q_r.sz[GMA_IDX_IO]) begin
      grow_val = q_r.sz[GMA_IDX_IO];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command parser and allocation sequence
  always_comb begin
    q_nxt = q_r;
    q_nxt.io_clr = 1'b0;
    q_nxt.buf_clr = 1'b0;
    q_nxt.prs_rst = 1'b0;
    if (config_grow_in && q_r.st == GMA_IDLE) begin
      q_nxt.logical = grow_val;
    end
    unique case (q_r.st)
      GMA_IDLE: begin
        if (cmd_valid_in && cmd_byte_in == GMA_CH_ESC) begin
          q_nxt.st = GMA_DOT;
        end
      end

      GMA_DOT: begin
        if (cmd_valid_in) begin
          q_nxt.st = (cmd_byte_in == GMA_CH_DOT) ? GMA_FUNC : GMA_IDLE;
        end
      end

      GMA_FUNC: begin
        if (cmd_valid_in) begin
          if (cmd_byte_in == GMA_CH_ALLOC) begin
            q_nxt.st = GMA_PARAM;
            q_nxt.idx = 3'h0;
            q_nxt.acc = '0;
            q_nxt.pres = '0;
          end else begin
            q_nxt.st = GMA_IDLE;
          end
        end
      end

      // digits build the value, a delimiter stores it in the next slot
      GMA_PARAM: begin
        if (cmd_valid_in) begin
          if (is_digit) begin
            q_nxt.acc = acc_sat;
            if (slot_ok) begin
              q_nxt.pres[q_r.idx] = 1'b1;
            end
          end else if (is_delim) begin
            if (slot_ok) begin
              q_nxt.req[q_r.idx] = q_r.acc;
              q_nxt.idx = q_r.idx + 3'h1;
            end
            q_nxt.acc = '0;
            if (cmd_byte_in == GMA_CH_COLON) begin
              q_nxt.st = GMA_FLUSH;
            end
          end
        end
      end

      // clear the io buffer before anything else
      GMA_FLUSH: begin
        q_nxt.io_clr = 1'b1;
        q_nxt.st = GMA_DRAIN;
      end

      // hold here until the vector buffer has emptied
      GMA_DRAIN: begin
        if (vector_empty_in) begin
          q_nxt.sz = cond;
          q_nxt.done = '0;
          q_nxt.st = GMA_REDUCE;
        end
      end

      // one buffer cut per cycle until the total fits
      GMA_REDUCE: begin
        if (excess != '0 && big_ok) begin
          q_nxt.sz[big] = cut;
          q_nxt.done[big] = 1'b1;
        end else begin
          // leftover after the fit goes to replot
          q_nxt.sz[GMA_IDX_RP] = W'(q_r.sz[GMA_IDX_RP] + slack);
          q_nxt.st = GMA_COMMIT;
        end
      end

      // buffer clear, parser reset and logical clamp land together, one cycle after the sizes
      GMA_COMMIT: begin
        q_nxt.buf_clr = 1'b1;
        q_nxt.prs_rst = 1'b1;
        if (q_r.logical > q_r.sz[GMA_IDX_IO]) begin
          q_nxt.logical = q_r.sz[GMA_IDX_IO];
        end
        q_nxt.st = GMA_IDLE;
      end
    endcase
    // capacities track the size that stands next cycle, so no divider sits on the output path
    q_nxt.cap_on = q_nxt.sz[GMA_IDX_VC] / W'(GMA_VEC_BYTES_ON);
    q_nxt.cap_off = q_nxt.sz[GMA_IDX_VC] / W'(GMA_VEC_BYTES_OFF);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; reset leaves the power-on allocation in place
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      q_r.st <= GMA_IDLE;
      q_r.idx <= 3'h0;
      q_r.acc <= '0;
      q_r.pres <= '0;
      q_r.req <= '0;
      q_r.sz <= {GMA_VC_DEF, GMA_RP_DEF, GMA_CH_DEF, GMA_PG_DEF, GMA_IO_DEF};
      q_r.done <= '0;
      q_r.logical <= GMA_IO_DEF;
      q_r.cap_on <= W'(GMA_VC_DEF / GMA_VEC_BYTES_ON);
      q_r.cap_off <= W'(GMA_VC_DEF / GMA_VEC_BYTES_OFF);
      q_r.io_clr <= 1'b0;
      q_r.buf_clr <= 1'b0;
      q_r.prs_rst <= 1'b0;
    end else begin
      q_r <= q_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  always_comb begin
    vector_capacity_out = curve_on_in ? q_r.cap_on : q_r.cap_off;
    vector_full_out = vector_count_in >= vector_capacity_out;
    group_release_out = curve_on_in && vector_full_out;
    pen_stop_out = !curve_on_in;
    panel_hold_out = (panel_pending_in != '0) && (vector_count_in != '0);
    io_full_out = io_queued_in >= q_r.logical;
  end

  // pulses and sizes come straight from the state flops
  assign io_clear_out = q_r.io_clr;
  assign buffers_clear_out = q_r.buf_clr;
  assign parser_reset_out = q_r.prs_rst;

  // bytes are refused while this is high
  always_comb begin
    unique case (q_r.st)
      GMA_FLUSH, GMA_DRAIN, GMA_REDUCE, GMA_COMMIT: begin
        busy_out = 1'b1;
      end
      GMA_IDLE, GMA_DOT, GMA_FUNC, GMA_PARAM: begin
        busy_out = 1'b0;
      end
    endcase
  end

  assign io_size_out = q_r.sz[GMA_IDX_IO];
  assign poly_size_out = q_r.sz[GMA_IDX_PG];
  assign glyph_size_out = q_r.sz[GMA_IDX_CH];
  assign replot_size_out = q_r.sz[GMA_IDX_RP];
  assign vector_size_out = q_r.sz[GMA_IDX_VC];
  assign logical_size_out = q_r.logical;
endmodule
`default_nettype wire

// ### tb/gma_chk.sv
// checker for the graphics memory allocator, bound to its top module
// assumes the 14-bit size ports and one clock domain
`timescale 1ns/1ns
`default_nettype none
module gma_chk #(
  parameter int W = 14
) (
  input wire logic clk_in, // clock
  input wire logic reset_n_in, // reset
  input wire logic curve_on_in, // curve mode
  input wire logic vector_empty_in, // drained
  input wire logic [W-1:0] io_queued_in, // queued
  input wire logic [W-1:0] vector_count_in, // vectors
  input wire logic [W-1:0] panel_pending_in, // panel
  input wire logic io_clear_out, // flush
  input wire logic buffers_clear_out, // clear
  input wire logic parser_reset_out, // parser
  input wire logic busy_out, // busy
  input wire logic [W-1:0] io_size_out, // io
  input wire logic [W-1:0] poly_size_out, // poly
  input wire logic [W-1:0] glyph_size_out, // glyph
  input wire logic [W-1:0] replot_size_out, // replot
  input wire logic [W-1:0] vector_size_out, // vector
  input wire logic [W-1:0] logical_size_out, // logical
  input wire logic io_full_out, // full
  input wire logic [W-1:0] vector_capacity_out, // capacity
  input wire logic group_release_out, // group
  input wire logic pen_stop_out, // stop
  input wire logic panel_hold_out // hold
);
  import gma_pkg::*;
  logic [W+2:0] sum_w;
  assign sum_w = {3'h0, io_size_out} + {3'h0, poly_size_out} + {3'h0, glyph_size_out} + {3'h0, replot_size_out}
    + {3'h0, vector_size_out};
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  //////////////////////////////////////////////
  AST_TOTAL: assert property (!busy_out |-> sum_w == GMA_TOTAL)
    else $error("buffer total wrong");
  AST_EVEN: assert property ({io_size_out[0], poly_size_out[0], glyph_size_out[0], replot_size_out[0],
    vector_size_out[0]} == 5'h00) else $error("odd size");
  AST_MIN: assert property (io_size_out >= GMA_IO_MIN && poly_size_out >= GMA_PG_MIN
    && vector_size_out >= GMA_VC_MIN) else $error("size below floor");
  AST_LOGIC: assert property (!busy_out |-> logical_size_out <= io_size_out)
    else $error("logical above physical");
  AST_DONE: assert property (buffers_clear_out |-> parser_reset_out && !busy_out && $past(busy_out))
    else $error("bad completion");
  AST_DRAIN: assert property (io_clear_out && !vector_empty_in |=> busy_out && !buffers_clear_out)
    else $error("no drain wait");
  AST_CAP: assert property (vector_capacity_out ==
    vector_size_out / (curve_on_in ? GMA_VEC_BYTES_ON : GMA_VEC_BYTES_OFF)) else $error("capacity wrong");
  AST_MODE: assert property (pen_stop_out == !curve_on_in
    && group_release_out == (curve_on_in && vector_count_in >= vector_capacity_out)) else $error("mode wrong");
  AST_PANEL: assert property (panel_hold_out == (panel_pending_in != 0 && vector_count_in != 0))
    else $error("panel hold wrong");
  AST_FULL: assert property (io_full_out == (io_queued_in >= logical_size_out))
    else $error("io full wrong");
endmodule
bind gma_allocator gma_chk #(.W(W)) i_chk (.clk_in, .reset_n_in, .curve_on_in, .vector_empty_in, .io_queued_in,
  .vector_count_in, .panel_pending_in, .io_clear_out, .buffers_clear_out, .parser_reset_out, .busy_out, .io_size_out,
  .poly_size_out, .glyph_size_out, .replot_size_out, .vector_size_out, .logical_size_out, .io_full_out,
  .vector_capacity_out, .group_release_out, .pen_stop_out, .panel_hold_out);
`default_nettype wire

// ### tb/gma_host.sv
// host model: sends command strings one byte per cycle
// assumes bytes are changed at the falling edge
`timescale 1ns/1ns
`default_nettype none
module gma_host (
  input wire logic clk_in, // clock
  output logic [7:0] byte_out, // byte
  output logic valid_out // strobe
);
  initial begin
    byte_out = 8'h00;
    valid_out = 1'b0;
  end
  task automatic send(input string s);
    foreach (s[i]) begin
      @(negedge clk_in);
      byte_out = s[i];
      valid_out = 1'b1;
    end
    @(negedge clk_in);
    valid_out = 1'b0;
    byte_out = ~byte_out; // released bus must not look like a stale byte
  endtask
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench for the graphics memory allocator
// assumes the host model and the bound checker
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import gma_pkg::*;
  logic clk_in, reset_n_in, glyphs_defined_in, curve_on_in, vector_empty_in, config_grow_in, cmd_valid_in;
  logic [7:0] cmd_byte_in;
  logic [13:0] config_logical_in, io_queued_in, vector_count_in, panel_pending_in;
  logic io_clear_out, buffers_clear_out, parser_reset_out, busy_out, io_full_out, vector_full_out;
  logic group_release_out, pen_stop_out, panel_hold_out;
  logic [13:0] io_size_out, poly_size_out, glyph_size_out, replot_size_out, vector_size_out, logical_size_out;
  logic [13:0] vector_capacity_out;
  int err_total, num_checks, cyc;
  gma_host i_host (.clk_in, .byte_out(cmd_byte_in), .valid_out(cmd_valid_in));
  gma_allocator #(.W(14)) i_dut (.clk_in, .reset_n_in, .cmd_byte_in, .cmd_valid_in, .glyphs_defined_in,
    .curve_on_in, .vector_empty_in, .config_grow_in, .config_logical_in, .io_queued_in, .vector_count_in,
    .panel_pending_in, .io_clear_out, .buffers_clear_out, .parser_reset_out, .busy_out, .io_size_out,
    .poly_size_out, .glyph_size_out, .replot_size_out, .vector_size_out, .logical_size_out, .io_full_out,
    .vector_capacity_out, .vector_full_out, .group_release_out, .pen_stop_out, .panel_hold_out);
  //////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [13:0] got, input logic [13:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic wait_done(input logic [13:0] e[5]);
    int n;
    n = 0;
    while (buffers_clear_out !== 1'b1 && n < 300) begin
      @(negedge clk_in);
      n++;
    end
    check("parser reset", {13'h0, parser_reset_out}, 14'h0001);
    check("io", io_size_out, e[0]);
    check("poly", poly_size_out, e[1]);
    check("glyph", glyph_size_out, e[2]);
    check("replot", replot_size_out, e[3]);
    check("vector", vector_size_out, e[4]);
    @(negedge clk_in);
  endtask
  task automatic alloc(input string p, input logic [13:0] e[5]);
    i_host.send({"\033.T", p, ":"});
    wait_done(e);
  endtask
  task automatic grow(input logic [13:0] v);
    config_logical_in = v;
    config_grow_in = 1'b1;
    @(negedge clk_in);
    config_grow_in = 1'b0;
    @(negedge clk_in);
  endtask
  //////////////////////////////////////////////
  task automatic t_sizes();
    i_host.send("X");
    alloc("", '{GMA_IO_DEF, GMA_PG_DEF, GMA_CH_DEF, GMA_RP_DEF, GMA_VC_DEF});
    alloc("1;5;;0;43", '{14'h0002, 14'h0004, 14'h0000, 14'h31CE, 14'h002C});
    check("logical", logical_size_out, 14'h0002);
    grow(14'h0064);
    check("logical", logical_size_out, 14'h0002);
    alloc("", '{GMA_IO_DEF, GMA_PG_DEF, GMA_CH_DEF, GMA_RP_DEF, GMA_VC_DEF});
    check("logical", logical_size_out, 14'h0002);
    grow(14'h01F4);
    check("logical", logical_size_out, 14'h01F4);
    io_queued_in = 14'h01F3;
    #1 check("full", {13'h0, io_full_out}, 14'h0000);
    io_queued_in = 14'h01F4;
    #1 check("full", {13'h0, io_full_out}, 14'h0001);
    $display("test sizes done");
  endtask
  task automatic t_reduce();
    alloc("7024;7050;7076;0;100", '{14'h1B70, 14'h162C, 14'h0000, 14'h0000, 14'h0064});
    glyphs_defined_in = 1'b1;
    alloc(";;100", '{GMA_IO_DEF, GMA_PG_DEF, 14'h01C4, 14'h251E, GMA_VC_DEF});
    $display("test reduce done");
  endtask
  task automatic t_drain();
    vector_empty_in = 1'b0;
    i_host.send("\033.T:");
    @(negedge clk_in);
    check("io clear", {13'h0, io_clear_out}, 14'h0001);
    repeat (19) @(negedge clk_in);
    check("busy", {13'h0, busy_out}, 14'h0001);
    vector_empty_in = 1'b1;
    wait_done('{GMA_IO_DEF, GMA_PG_DEF, 14'h01C4, 14'h251E, GMA_VC_DEF});
    $display("test drain done");
  endtask
  task automatic t_vector();
    curve_on_in = 1'b0;
    #1 check("capacity", vector_capacity_out, 14'h0002);
    check("pen stop", {13'h0, pen_stop_out}, 14'h0001);
    check("vector full", {13'h0, vector_full_out}, 14'h0000);
    curve_on_in = 1'b1;
    vector_count_in = 14'h0004;
    panel_pending_in = 14'h0001;
    #1 check("capacity", vector_capacity_out, 14'h0004);
    check("group", {13'h0, group_release_out}, 14'h0001);
    check("vector full", {13'h0, vector_full_out}, 14'h0001);
    check("panel", {13'h0, panel_hold_out}, 14'h0001);
    vector_count_in = 14'h0000;
    #1 check("panel", {13'h0, panel_hold_out}, 14'h0000);
    $display("test vector done");
  endtask
  //////////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end
  initial begin
    {reset_n_in, glyphs_defined_in, curve_on_in, config_grow_in} = 4'h0;
    vector_empty_in = 1'b1;
    {config_logical_in, io_queued_in, vector_count_in, panel_pending_in} = 56'h0;
    repeat (3) @(negedge clk_in);
    reset_n_in = 1'b1;
    t_sizes();
    t_reduce();
    t_drain();
    t_vector();
    report_and_stop();
  end
endmodule
`default_nettype wire
